// ### sbm_defs.svh
// Behaviour
// - in backup sleep, compare against the backup threshold level, not the normal one
// - main supply below threshold: take chosen action, interrupt, reset or battery switch
// - when monitoring the battery, compare it against the backup threshold level
// - battery below backup threshold: interrupt or reset only, never battery switch
// - current detection result readable as brownout detected flag in status
// - at start-up and power-on reset, load configuration from non-volatile user row
// - after reset run in continuous mode unless configuration selects sampling
// - enabled with current mode's sampling select zero means continuous monitoring
// - monitor select chooses main supply or backup battery as monitored input
// - sampling: enable detector each tick, watch briefly, then disable until next tick
// - sample in active when active select is one, in standby when standby select is one
// - sampling tick is prescaler clock divided by two to the power prescale plus one
// - prescaler input is the 1 kHz clock from the ultra low power oscillator
// - synchronise the sampling domain signals into the bus clock domain
`ifndef SBM_DEFS_SVH
`define SBM_DEFS_SVH
// ==========================================
// register offsets
`define SBM_CFG_OFS 8'h00
`define SBM_STATUS_OFS 8'h04
`define SBM_LEVEL_OFS 8'h08
// ==========================================
// configuration field positions
`define SBM_CFG_ENABLE 0
`define SBM_CFG_ACT_SAMPLE 1
`define SBM_CFG_STBY_SAMPLE 2
`define SBM_CFG_MON_SEL 3
`define SBM_CFG_ACT_LO 4
`define SBM_CFG_PSEL_LO 8
`define SBM_CFG_RESET 32'h0000_0001
`define SBM_LEVEL_RESET 32'h0000_0000
// ==========================================
// timing: settle window of an awakened detector
`define SBM_SETTLE_CYCLES 4'h3
`define SBM_AXI_OKAY 2'h0
`define SBM_AXI_SLVERR 2'h2
`endif

// ### sbm_pkg.sv
package sbm_pkg;
   typedef enum logic [1:0] {
      SBM_ACT_NONE = 2'h0,
      SBM_ACT_INT = 2'h1,
      SBM_ACT_RESET = 2'h2,
      SBM_ACT_BATSW = 2'h3
   } sbm_action_t;
   // gray ordered sampling sequence
   typedef enum logic [1:0] {
      SBM_IDLE = 2'b00,
      SBM_WAKE = 2'b01,
      SBM_JUDGE = 2'b11
   } sbm_state_t;
endpackage : sbm_pkg

// ### sbm_sync.sv
`timescale 1ns/100ps
`default_nettype none
module sbm_sync (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // level in and out
   input wire logic d_i,
   output logic q_o
);
   logic meta_reg;
   // first stage read only by the second
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         meta_reg <= 1'b0;
         q_o <= 1'b0;
      end else begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule : sbm_sync
`default_nettype wire

// ### sbm_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module sbm_prescaler (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // synchronised 1 khz level and select
   input wire logic lp_clk_i,
   input wire logic [3:0] psel_i,
   // one cycle sampling tick
   output logic tick_o
);
   logic lp_last_reg;
   logic [16:0] div_reg;
   logic lp_rise;
   assign lp_rise = lp_clk_i & ~lp_last_reg;
   // count 1 khz edges, tick every 2^(psel+1) of them
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         lp_last_reg <= 1'b0;
         div_reg <= 17'h0;
         tick_o <= 1'b0;
      end else begin
         lp_last_reg <= lp_clk_i;
         tick_o <= 1'b0;
         if (lp_rise) begin
            if (div_reg >= ((17'h2 << psel_i) - 17'h1)) begin
               div_reg <= 17'h0;
               tick_o <= 1'b1;
            end else begin
               div_reg <= div_reg + 17'h1;
            end
         end
      end
   end
endmodule : sbm_prescaler
`default_nettype wire

// ### sbm_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "sbm_defs.svh"
module sbm_ctrl (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // non-volatile user row load
   input wire logic [31:0] nvm_cfg_i,
   input wire logic [31:0] nvm_level_i,
   input wire logic nvm_valid_i,
   // chip power state, from the power manager
   input wire logic standby_i,
   input wire logic backup_sleep_i,
   // 1 khz low power clock, asynchronous
   input wire logic lp_clk_1khz_i,
   // analog comparator
   input wire logic cmp_below_i,
   output logic cmp_enable_o,
   output logic cmp_vbat_o,
   output logic [5:0] cmp_level_o,
   // actions
   output logic main_brownout_irq_o,
   output logic main_brownout_reset_o,
   output logic battery_switch_o
);
   import sbm_pkg::*;

   // ==========================================
   // configuration registers
   logic [31:0] cfg_reg;
   logic [31:0] level_reg;
   logic loaded_reg;
   logic enable;
   logic active_sampling_select;
   logic standby_sampling_select;
   logic monitor_select;
   sbm_action_t action;
   logic [3:0] psel;
   logic [5:0] normal_level;
   logic [5:0] backup_threshold_level;
   // field decode; bits outside the fields are stored but steer nothing
   assign enable = cfg_reg[`SBM_CFG_ENABLE];
   assign active_sampling_select = cfg_reg[`SBM_CFG_ACT_SAMPLE];
   assign standby_sampling_select = cfg_reg[`SBM_CFG_STBY_SAMPLE];
   assign monitor_select = cfg_reg[`SBM_CFG_MON_SEL];
   assign action = sbm_action_t'(cfg_reg[`SBM_CFG_ACT_LO +: 2]);
   assign psel = cfg_reg[`SBM_CFG_PSEL_LO +: 4];
   // both thresholds share one word, six bits each
   assign normal_level = level_reg[5:0];
   assign backup_threshold_level = level_reg[13:8];

   // ==========================================
   // axi4-lite slave
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic do_write;
   logic [31:0] cfg_wr;
   logic [31:0] level_wr;
   logic wr_hit;
   // a write lands once both halves are in and the last answer is gone
   assign do_write = aw_hold_reg & w_hold_reg & ~s_axi_bvalid_o;
   // status is read only, so a write there is answered and dropped
   assign wr_hit = (aw_addr_reg == `SBM_CFG_OFS) || (aw_addr_reg == `SBM_LEVEL_OFS) ||
      (aw_addr_reg == `SBM_STATUS_OFS);
   // byte-lane merge of a write
   always_comb begin
      cfg_wr = cfg_reg;
      level_wr = level_reg;
      for (int i = 0; i < 4; i++) begin
         if (w_strb_reg[i]) begin
            cfg_wr[i*8 +: 8] = w_data_reg[i*8 +: 8];
            level_wr[i*8 +: 8] = w_data_reg[i*8 +: 8];
         end
      end
   end

   // address side: ready is a one-cycle pulse, so a held valid is never taken twice
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         s_axi_awready_o <= 1'b0;
      end else begin
         s_axi_awready_o <= ~aw_hold_reg & ~s_axi_awready_o & s_axi_awvalid_i;
         if (s_axi_awvalid_i & s_axi_awready_o) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr_i[7:2], 2'b00};
         end
         if (do_write) begin
            aw_hold_reg <= 1'b0;
         end
      end
   end

   // data side, same pulse scheme, taken in either order against the address
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         w_hold_reg <= 1'b0;
         w_data_reg <= 32'h0;
         w_strb_reg <= 4'h0;
         s_axi_wready_o <= 1'b0;
      end else begin
         s_axi_wready_o <= ~w_hold_reg & ~s_axi_wready_o & s_axi_wvalid_i;
         if (s_axi_wvalid_i & s_axi_wready_o) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_i;
            w_strb_reg <= s_axi_wstrb_i;
         end
         if (do_write) begin
            w_hold_reg <= 1'b0;
         end
      end
   end

   // response follows both halves and stands until bready
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= `SBM_AXI_OKAY;
      end else if (do_write) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o <= wr_hit ? `SBM_AXI_OKAY : `SBM_AXI_SLVERR;
      end else if (s_axi_bvalid_o & s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   // configuration: user row loads it, software may overwrite later
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cfg_reg <= `SBM_CFG_RESET;
         level_reg <= `SBM_LEVEL_RESET;
         loaded_reg <= 1'b0;
      end else if (!loaded_reg) begin
         // the user row wins over the bus until it has been seen once
         if (nvm_valid_i) begin
            cfg_reg <= nvm_cfg_i;
            level_reg <= nvm_level_i;
            loaded_reg <= 1'b1;
         end
      end else if (do_write) begin
         if (aw_addr_reg == `SBM_CFG_OFS) begin
            cfg_reg <= cfg_wr;
         end
         if (aw_addr_reg == `SBM_LEVEL_OFS) begin
            level_reg <= level_wr;
         end
      end
   end

   // ==========================================
   // sampling clock crossing and prescaler
   logic lp_sync;
   logic tick;
   logic stby_sync;
   logic bkup_sync;
   logic below_sync;
   // all analog and power-state levels are foreign to the bus clock
   sbm_sync u_sync_lp (.clk_i(clk_i), .resetn_i(resetn_i), .d_i(lp_clk_1khz_i), .q_o(lp_sync));
   sbm_sync u_sync_stby (.clk_i(clk_i), .resetn_i(resetn_i), .d_i(standby_i), .q_o(stby_sync));
   sbm_sync u_sync_bkup (.clk_i(clk_i), .resetn_i(resetn_i), .d_i(backup_sleep_i), .q_o(bkup_sync));
   sbm_sync u_sync_cmp (.clk_i(clk_i), .resetn_i(resetn_i), .d_i(cmp_below_i), .q_o(below_sync));
   // the divider sees only the synchronised copy of the slow clock
   sbm_prescaler u_presc (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .lp_clk_i(lp_sync),
      .psel_i(psel),
      .tick_o(tick)
   );

   // ==========================================
   // detector sequencing
   logic sampling;
   sbm_state_t state_reg;
   logic [3:0] settle_reg;
   logic det_reg;
   logic low_standby;
   // backup sleep is a deeper standby and shares its sampling choice
   assign low_standby = stby_sync | bkup_sync;
   // the select of the current power mode picks sampling
   assign sampling = low_standby ? standby_sampling_select : active_sampling_select;

   // continuous mode tracks the comparator; sampled mode wakes once per tick
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_reg <= SBM_IDLE;
         settle_reg <= 4'h0;
         det_reg <= 1'b0;
         cmp_enable_o <= 1'b0;
      end else if (!enable) begin
         state_reg <= SBM_IDLE;
         det_reg <= 1'b0;
         cmp_enable_o <= 1'b0;
      end else if (!sampling) begin
         state_reg <= SBM_IDLE;
         cmp_enable_o <= 1'b1;
         // a freshly powered detector and its synchroniser still hold stale levels
         if (!cmp_enable_o) begin
            settle_reg <= `SBM_SETTLE_CYCLES;
         end else if (settle_reg != 4'h0) begin
            settle_reg <= settle_reg - 4'h1;
         end else begin
            det_reg <= below_sync;
         end
      end else begin
         case (state_reg)
            SBM_IDLE: begin
               // off between ticks, the detector draws no current
               cmp_enable_o <= 1'b0;
               if (tick) begin
                  cmp_enable_o <= 1'b1;
                  settle_reg <= `SBM_SETTLE_CYCLES;
                  state_reg <= SBM_WAKE;
               end
            end
            SBM_WAKE: begin
               // synchroniser delay must pass before the result is trusted
               if (settle_reg == 4'h0) begin
                  state_reg <= SBM_JUDGE;
               end else begin
                  settle_reg <= settle_reg - 4'h1;
               end
            end
            SBM_JUDGE: begin
               // sample at the end of the window, then power down at once
               det_reg <= below_sync;
               cmp_enable_o <= 1'b0;
               state_reg <= SBM_IDLE;
            end
            default: begin
               state_reg <= SBM_IDLE;
               cmp_enable_o <= 1'b0;
            end
         endcase
      end
   end

   // input selection toward the comparator
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cmp_vbat_o <= 1'b0;
      end else begin
         cmp_vbat_o <= monitor_select;
      end
   end

   // reference: battery monitoring and backup sleep both use the backup threshold
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cmp_level_o <= 6'h00;
      end else begin
         if (monitor_select || bkup_sync) begin
            cmp_level_o <= backup_threshold_level;
         end else begin
            cmp_level_o <= normal_level;
         end
      end
   end

   // ==========================================
   // detection actions
   // levels, not pulses: they follow the held result while the action matches
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         main_brownout_irq_o <= 1'b0;
         main_brownout_reset_o <= 1'b0;
         battery_switch_o <= 1'b0;
      end else begin
         main_brownout_irq_o <= det_reg && (action == SBM_ACT_INT);
         main_brownout_reset_o <= det_reg && (action == SBM_ACT_RESET);
         // a battery cannot switch to itself, so vbat monitoring drops it
         battery_switch_o <= det_reg && (action == SBM_ACT_BATSW) && !monitor_select;
      end
   end

   // ==========================================
   // read channel, one request at a time
   logic [31:0] rd_word;
   logic [7:0] rd_addr;
   logic [31:0] status_word;
   // byte lanes below a word are ignored, as on the write side
   assign rd_addr = {s_axi_araddr_i[7:2], 2'b00};
   // the flag shows the result held by the detector, whatever the action
   assign status_word = {30'h0, loaded_reg, det_reg};
   // read mux
   always_comb begin
      case (rd_addr)
         `SBM_CFG_OFS: rd_word = cfg_reg;
         `SBM_STATUS_OFS: rd_word = status_word;
         `SBM_LEVEL_OFS: rd_word = level_reg;
         default: rd_word = 32'h0;
      endcase
   end

   // answer one cycle after the address is taken; rdata stands until rready
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0;
         s_axi_rresp_o <= `SBM_AXI_OKAY;
      end else begin
         s_axi_arready_o <= 1'b0;
         if (s_axi_rvalid_o) begin
            if (s_axi_rready_i) begin
               s_axi_rvalid_o <= 1'b0;
            end
         end else if (s_axi_arvalid_i && !s_axi_arready_o) begin
            s_axi_arready_o <= 1'b1;
         end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_word;
            case (rd_addr)
               `SBM_CFG_OFS, `SBM_STATUS_OFS, `SBM_LEVEL_OFS: s_axi_rresp_o <= `SBM_AXI_OKAY;
               default: s_axi_rresp_o <= `SBM_AXI_SLVERR;
            endcase
         end
      end
   end
endmodule : sbm_ctrl
`default_nettype wire

// ### sbm_ctrl_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port checker
module sbm_checker (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // bus handshakes
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // detector and actions
   input wire logic cmp_below_i,
   input wire logic cmp_enable_o,
   input wire logic cmp_vbat_o,
   input wire logic main_brownout_irq_o,
   input wire logic main_brownout_reset_o,
   input wire logic battery_switch_o
);
   logic [3:0] below_age_reg;
   logic [3:0] en_age_reg;
   logic [2:0] act;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   assign act = {battery_switch_o, main_brownout_reset_o, main_brownout_irq_o};
   // ages saturate so a long quiet spell never wraps
   always_ff @(posedge clk_i) begin
      if (!resetn_i || cmp_below_i) below_age_reg <= 4'h0;
      else if (below_age_reg != 4'hf) below_age_reg <= below_age_reg + 4'h1;
   end
   always_ff @(posedge clk_i) begin
      if (!resetn_i || cmp_enable_o) en_age_reg <= 4'h0;
      else if (en_age_reg != 4'hf) en_age_reg <= en_age_reg + 4'h1;
   end
   sequence s_ar_taken;
      s_axi_arvalid_i && s_axi_arready_o;
   endsequence
   a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid_o)
      else $error("no read answer");
   a_arready_pulse: assert property (s_axi_arready_o |=> !s_axi_arready_o)
      else $error("arready held");
   a_rvalid_drop: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
      else $error("rvalid held");
   a_bvalid_drop: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
      else $error("bvalid held");
   a_action_single: assert property ($onehot0(act))
      else $error("two actions");
   a_no_bat_switch: assert property (battery_switch_o |-> !cmp_vbat_o)
      else $error("switch on battery");
   a_action_cause: assert property (|(act & ~$past(act)) |-> below_age_reg < 4'ha)
      else $error("action without cause");
   a_hold_between: assert property ($changed(act) |-> en_age_reg < 4'ha)
      else $error("result moved while off");
endmodule : sbm_checker
bind sbm_ctrl sbm_checker u_checker (.clk_i, .resetn_i, .s_axi_arvalid_i, .s_axi_arready_o,
   .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_bvalid_o, .s_axi_bready_i, .cmp_below_i, .cmp_enable_o,
   .cmp_vbat_o, .main_brownout_irq_o, .main_brownout_reset_o, .battery_switch_o);
`default_nettype wire

// ### sbm_analog_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// supply comparator and low power clock
module sbm_analog_model #(
   parameter int LP_HALF_NS = 1013
) (
   // bus clock
   input wire logic clk_i,
   // detector control
   input wire logic cmp_enable_i,
   input wire logic cmp_vbat_i,
   input wire logic [5:0] cmp_level_i,
   // supply levels, threshold scale
   input wire logic [5:0] vdd_i,
   input wire logic [5:0] vbat_i,
   // answers
   output logic cmp_below_o,
   output logic lp_clk_o
);
   // sped up from 1 khz so sampling runs stay short
   initial lp_clk_o = 1'b0;
   always #(LP_HALF_NS) lp_clk_o = ~lp_clk_o;
   // an unpowered detector has no valid answer, so it chatters
   initial cmp_below_o = 1'b0;
   always @(posedge clk_i) begin
      if (cmp_enable_i) cmp_below_o <= #3 ((cmp_vbat_i ? vbat_i : vdd_i) < cmp_level_i);
      else cmp_below_o <= #3 ~cmp_below_o;
   end
endmodule : sbm_analog_model
`default_nettype wire

// ### tb_supply_brownout_monitor_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "sbm_defs.svh"
`define CHK(n, e, a) chk(n, 32'(e), 32'(a))
// ==========================================
// bench
module tb_supply_brownout_monitor_ctrl;
   import sbm_pkg::*;
   localparam logic [7:0] CFG = `SBM_CFG_OFS;
   localparam logic [7:0] STA = `SBM_STATUS_OFS;
   logic clk_i = 1'b0, resetn_i = 1'b0, nvm_valid_i = 1'b0, standby_i = 1'b0, backup_sleep_i = 1'b0;
   logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_arvalid_i = 1'b0;
   logic s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1;
   logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
   logic [31:0] s_axi_wdata_i = 32'h0, nvm_cfg_i = 32'h11, nvm_level_i = 32'ha14, rd_data;
   logic [3:0] s_axi_wstrb_i = 4'hf;
   logic [5:0] vdd_lvl = 6'h1e, vbat_lvl = 6'h1e, cmp_level_o;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic [31:0] s_axi_rdata_o;
   logic lp_clk_1khz_i, cmp_below_i, cmp_enable_o, cmp_vbat_o;
   logic main_brownout_irq_o, main_brownout_reset_o, battery_switch_o;
   wire [2:0] act_w = {battery_switch_o, main_brownout_reset_o, main_brownout_irq_o};
   int err_count = 0, checks_done = 0, edges, hi;
   sbm_ctrl DUT (.clk_i, .resetn_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
      .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
      .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
      .s_axi_rready_i, .nvm_cfg_i, .nvm_level_i, .nvm_valid_i, .standby_i, .backup_sleep_i, .lp_clk_1khz_i,
      .cmp_below_i, .cmp_enable_o, .cmp_vbat_o, .cmp_level_o, .main_brownout_irq_o, .main_brownout_reset_o,
      .battery_switch_o);
   sbm_analog_model u_analog (.clk_i, .cmp_enable_i(cmp_enable_o), .cmp_vbat_i(cmp_vbat_o),
      .cmp_level_i(cmp_level_o), .vdd_i(vdd_lvl), .vbat_i(vbat_lvl), .cmp_below_o(cmp_below_i),
      .lp_clk_o(lp_clk_1khz_i));
   always #20 clk_i = ~clk_i;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] a);
      checks_done++;
      if (a !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, a);
      end
   endtask : chk
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask : wt
   // address and data offered together, each dropped once taken
   // no limit of its own: only the watchdog ends a wait for the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      end while (s_axi_bvalid_o !== 1'b1);
      resp = s_axi_bresp_o;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      end while (s_axi_rvalid_o !== 1'b1);
      rd_data = s_axi_rdata_o;
      resp = s_axi_rresp_o;
   endtask : rd
   // rising edges and high cycles of the detector enable
   task automatic count(input int n);
      logic prev = cmp_enable_o;
      edges = 0;
      hi = 0;
      repeat (n) begin
         @(posedge clk_i);
         edges += int'(cmp_enable_o && !prev);
         hi += int'(cmp_enable_o);
         prev = cmp_enable_o;
      end
   endtask : count
   task automatic t_load;
      rd(CFG);
      `CHK("cfg reset", `SBM_CFG_RESET, rd_data);
      wr(CFG, 32'h3f);
      `CHK("early resp", `SBM_AXI_OKAY, resp);
      rd(CFG);
      `CHK("cfg early", `SBM_CFG_RESET, rd_data);
      nvm_valid_i <= 1'b1;
      wt(2);
      rd(CFG);
      `CHK("cfg load", 32'h11, rd_data);
      rd(`SBM_LEVEL_OFS);
      `CHK("level load", 32'ha14, rd_data);
      rd(STA);
      `CHK("loaded", 1'b1, rd_data[1]);
      rd(8'h0c);
      `CHK("unmapped", `SBM_AXI_SLVERR, resp);
      wr(8'h0c, 32'h0);
      `CHK("unmapped wr", `SBM_AXI_SLVERR, resp);
      wr(STA, 32'h1);
      rd(STA);
      `CHK("status ro", 1'b0, rd_data[0]);
   endtask : t_load
   // every action code on the main supply, then codes 1 to 3 on the battery
   task automatic t_act;
      `CHK("cont enable", 1'b1, cmp_enable_o);
      `CHK("main level", 6'h14, cmp_level_o);
      vdd_lvl <= 6'h0a;
      for (int a = 0; a < 4; a++) begin
         wr(CFG, 32'h1 | (32'(a) << 4));
         wt(10);
         `CHK("main action", 3'((4'h1 << a) >> 1), act_w);
      end
      rd(STA);
      `CHK("detected", 1'b1, rd_data[0]);
      vdd_lvl <= 6'h1e;
      vbat_lvl <= 6'h05;
      for (int a = 1; a < 4; a++) begin
         wr(CFG, 32'h9 | (32'(a) << 4));
         wt(10);
         `CHK("bat action", 3'((4'h1 << a) >> 1) & 3'h3, act_w);
      end
      `CHK("bat select", 1'b1, cmp_vbat_o);
      `CHK("bat level", 6'h0a, cmp_level_o);
      vbat_lvl <= 6'h1e;
      wr(CFG, 32'h11);
      wt(10);
      rd(STA);
      `CHK("cleared", 1'b0, rd_data[0]);
   endtask : t_act
   task automatic t_backup;
      backup_sleep_i <= 1'b1;
      wt(5);
      vdd_lvl <= 6'h0f;
      wt(10);
      `CHK("sleep level", 6'h0a, cmp_level_o);
      `CHK("sleep irq", 1'b0, main_brownout_irq_o);
      backup_sleep_i <= 1'b0;
      wt(10);
      `CHK("awake irq", 1'b1, main_brownout_irq_o);
      vdd_lvl <= 6'h1e;
      wt(10);
   endtask : t_backup
   task automatic t_sample;
      wr(CFG, 32'h13);
      wt(20);
      count(1000);
      `CHK("psel0 ticks", 1'b1, edges >= 9 && edges <= 11);
      `CHK("short on", 1'b1, hi <= edges * 6);
      wr(CFG, 32'h113);
      count(1000);
      `CHK("psel1 ticks", 1'b1, edges >= 4 && edges <= 6);
      vdd_lvl <= 6'h0a;
      wt(500);
      `CHK("held low", 1'b1, main_brownout_irq_o);
      vdd_lvl <= 6'h1e;
      wt(500);
      `CHK("held ok", 1'b0, main_brownout_irq_o);
      wr(CFG, 32'h15);
      wt(20);
      count(200);
      `CHK("active cont", 200, hi);
      standby_i <= 1'b1;
      wt(20);
      count(500);
      `CHK("stby ticks", 1'b1, edges >= 4 && edges <= 6);
   endtask : t_sample
   initial begin
      wt(5);
      resetn_i <= 1'b1;
      wt(2);
      t_load();
      t_act();
      t_backup();
      t_sample();
      end_of_test();
   end
   // the run needs about 4000 cycles; five times that means a hang
   initial begin
      #800000;
      err_count++;
      end_of_test();
   end
endmodule : tb_supply_brownout_monitor_ctrl
`default_nettype wire
